// file: core/bsw_top.sv
// Top level of the two-digit BCD stopwatch with its register port.
`include "bsw_cfg.svh"
module bsw_top #(
  parameter int TICK_DIV = `BSW_TICK_DIV
) (
  // Clock and reset.
  input  wire logic       CLK_IN,
  input  wire logic       RESET_IN,
  // Register port.
  input  wire logic [15:0] ADDR_IN,
  input  wire logic [3:0]  WR_DATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [3:0]  RD_DATA_OUT,
  // Interrupt requests.
  output logic             IRQ_TEN_HZ_OUT,
  output logic             IRQ_ONE_HZ_OUT,
  // Status.
  output logic             RUNNING_OUT
);
  import bsw_pkg::*;

  // Functions used by the state update and the read path.

  // Wrap test of one BCD digit.
  function automatic logic is_nine(input logic [3:0] d);
    is_nine = (d == `BSW_DIGIT_NINE);
  endfunction

  // BCD increment of one digit, wrapping 9 to 0.
  function automatic logic [3:0] bcd_inc(input logic [3:0] d);
    if (is_nine(d))
    begin
      bcd_inc = `BSW_DIGIT_ZERO;
    end
    else
    begin
      bcd_inc = d + 4'h1;
    end
  endfunction

  // Address match of a register port request.
  function automatic logic hit(input bsw_bus_req_t r, input logic [15:0] a);
    hit = (r.addr == a);
  endfunction

  // Read data of the addressed register.
  function automatic logic [3:0] read_mux(input bsw_bus_req_t r, input bsw_state_t s);
    logic [3:0] v;
    v = `BSW_DATA_ZERO;
    case (r.addr)
      `BSW_ADDR_CTRL:
      begin
        // The clear bit is write-only, so only the run bit is returned.
        v[`BSW_BIT_RUN] = (s.run_state == ST_RUN);
      end
      `BSW_ADDR_HUND:
      begin
        v = s.hund;
      end
      `BSW_ADDR_TENTH:
      begin
        v = s.tenth;
      end
      `BSW_ADDR_MASK:
      begin
        v[`BSW_BIT_TEN_HZ] = s.mask_ten_hz;
        v[`BSW_BIT_ONE_HZ] = s.mask_one_hz;
      end
      `BSW_ADDR_FLAG:
      begin
        v[`BSW_BIT_TEN_HZ] = s.flag_ten_hz;
        v[`BSW_BIT_ONE_HZ] = s.flag_one_hz;
      end
      default:
      begin
        // Unmapped addresses read as zero.
        v = `BSW_DATA_ZERO;
      end
    endcase
    read_mux = v;
  endfunction

  // Signals.
  bsw_bus_req_t req;
  bsw_state_t   st;
  bsw_state_t   next_st;
  logic         tick;
  logic         adv;
  logic         wr_ctrl;
  logic         wr_mask;
  logic         wr_flag;
  logic         clear_req;
  logic         run_now;
  logic         wrap_hund;
  logic         wrap_tenth;

  assign req.addr  = ADDR_IN;
  assign req.wdata = WR_DATA_IN;
  assign req.wr    = WR_IN;
  assign req.rd    = RD_IN;

  assign run_now = (st.run_state == ST_RUN);

  // The clear strobe is taken straight from the write so the sequencer phase
  // restarts in the same cycle as the digits.
  assign wr_ctrl   = req.wr && hit(req, `BSW_ADDR_CTRL);
  assign wr_mask   = req.wr && hit(req, `BSW_ADDR_MASK);
  assign wr_flag   = req.wr && hit(req, `BSW_ADDR_FLAG);
  assign clear_req = wr_ctrl && req.wdata[`BSW_BIT_CLEAR];

  // Submodules.
  // The tick divider runs free from reset; run only gates the sequencer, so a
  // short stop keeps the tick count within the current hundredths step.
  bsw_tick_div #(
    .DIV (TICK_DIV)
  ) u_div (
    .clk_in   (CLK_IN),
    .rst_in   (RESET_IN),
    .tick_out (tick)
  );

  bsw_step_seq u_seq (
    .clk_in   (CLK_IN),
    .rst_in   (RESET_IN),
    .tick_in  (tick),
    .run_in   (run_now),
    .clear_in (clear_req),
    .hund_in  (st.hund),
    .tenth_in (st.tenth),
    .adv_out  (adv)
  );

  // Wrap events occur only on an advance that is not overridden by a clear.
  assign wrap_hund  = adv && !clear_req && is_nine(st.hund);
  assign wrap_tenth = wrap_hund && is_nine(st.tenth);

  always_comb
  begin
    next_st = st;

    // Run state machine; a control write always decides the next state.
    case (st.run_state)
      ST_STOP:
      begin
        if (wr_ctrl && req.wdata[`BSW_BIT_RUN])
        begin
          next_st.run_state = ST_RUN;
        end
        else
        begin
          next_st.run_state = ST_STOP;
        end
      end
      ST_RUN:
      begin
        if (wr_ctrl && !req.wdata[`BSW_BIT_RUN])
        begin
          next_st.run_state = ST_STOP;
        end
        else
        begin
          next_st.run_state = ST_RUN;
        end
      end
      default:
      begin
        next_st.run_state = ST_STOP;
      end
    endcase

    // Hundredths digit.
    // Clear zeros digits.
    if (clear_req)
    begin
      next_st.hund = `BSW_DIGIT_ZERO;
    end
    else if (adv)
    begin
      next_st.hund = bcd_inc(st.hund);
    end
    else
    begin
      next_st.hund = st.hund;
    end

    // Tenths digit, carried by the hundredths wrap.
    // A clear that meets a wrap leaves both digits at zero and sets no flag.
    // Cascaded tenths count.
    if (clear_req)
    begin
      next_st.tenth = `BSW_DIGIT_ZERO;
    end
    else if (wrap_hund)
    begin
      next_st.tenth = bcd_inc(st.tenth);
    end
    else
    begin
      next_st.tenth = st.tenth;
    end

    if (wr_mask)
    begin
      next_st.mask_ten_hz = req.wdata[`BSW_BIT_TEN_HZ];
      next_st.mask_one_hz = req.wdata[`BSW_BIT_ONE_HZ];
    end
    else
    begin
      next_st.mask_ten_hz = st.mask_ten_hz;
      next_st.mask_one_hz = st.mask_one_hz;
    end

    // An overflow in the same cycle as a write-one clear keeps the flag set,
    // so no event is lost to a service routine that clears late.
    // Overflow sets flag.
    if (wrap_hund)
    begin
      next_st.flag_ten_hz = 1'b1;
    end
    else if (wr_flag && req.wdata[`BSW_BIT_TEN_HZ])
    begin
      next_st.flag_ten_hz = 1'b0;
    end
    else
    begin
      next_st.flag_ten_hz = st.flag_ten_hz;
    end
    if (wrap_tenth)
    begin
      next_st.flag_one_hz = 1'b1;
    end
    else if (wr_flag && req.wdata[`BSW_BIT_ONE_HZ])
    begin
      next_st.flag_one_hz = 1'b0;
    end
    else
    begin
      next_st.flag_one_hz = st.flag_one_hz;
    end

    // Interrupt requests follow the flag and mask one cycle later.
    // Registering them keeps the request pins free of decode glitches.
    // Gated requests.
    if (st.flag_ten_hz && st.mask_ten_hz)
    begin
      next_st.irq_ten_hz = 1'b1;
    end
    else
    begin
      next_st.irq_ten_hz = 1'b0;
    end
    if (st.flag_one_hz && st.mask_one_hz)
    begin
      next_st.irq_one_hz = 1'b1;
    end
    else
    begin
      next_st.irq_one_hz = 1'b0;
    end

    // Read data stand only in the cycle after the read strobe.
    // Read path.
    if (req.rd)
    begin
      next_st.rdata = read_mux(req, st);
    end
    else
    begin
      next_st.rdata = `BSW_DATA_ZERO;
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      st           <= '0;
      st.run_state <= ST_STOP;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs.
  assign RD_DATA_OUT    = st.rdata;
  assign IRQ_TEN_HZ_OUT = st.irq_ten_hz;
  assign IRQ_ONE_HZ_OUT = st.irq_one_hz;
  // Bit one of the one-hot run code is high only in the run state, so the
  // status pin comes straight from its flip-flop.
  assign RUNNING_OUT    = st.run_state[1];

endmodule // bsw_top

// file: core/bsw_cfg.svh
// Address map, field positions, reset values and timing counts of the stopwatch.
`ifndef BSW_CFG_SVH
`define BSW_CFG_SVH

`define BSW_ADDR_W        16
`define BSW_DATA_W        4
`define BSW_ADDR_CTRL     16'hFF7C
`define BSW_ADDR_HUND     16'hFF7D
`define BSW_ADDR_TENTH    16'hFF7E
`define BSW_ADDR_MASK     16'hFFE7
`define BSW_ADDR_FLAG     16'hFFF7

`define BSW_BIT_RUN       0
`define BSW_BIT_CLEAR     1
`define BSW_BIT_TEN_HZ    0
`define BSW_BIT_ONE_HZ    1

`define BSW_DIGIT_ZERO    4'h0
`define BSW_DIGIT_NINE    4'h9
`define BSW_DATA_ZERO     4'h0

`define BSW_STEP_SHORT    2'h2
`define BSW_STEP_LONG     2'h3

`define BSW_CLK_HZ        200000000
`define BSW_TICK_HZ       256
`define BSW_TICK_DIV      (`BSW_CLK_HZ / `BSW_TICK_HZ)
`define BSW_DIV_W         20

`endif

// file: core/bsw_pkg.sv
// Types shared by the stopwatch modules.
package bsw_pkg;

  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN  = 2'b10
  } bsw_run_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [3:0]  wdata;
    logic        wr;
    logic        rd;
  } bsw_bus_req_t;

  typedef struct packed {
    logic [1:0] sub;
    logic       adv;
  } bsw_seq_state_t;

  typedef struct packed {
    logic [19:0] cnt;
    logic        tick;
  } bsw_div_state_t;

  typedef struct packed {
    bsw_run_t   run_state;
    logic [3:0] hund;
    logic [3:0] tenth;
    logic       mask_ten_hz;
    logic       mask_one_hz;
    logic       flag_ten_hz;
    logic       flag_one_hz;
    logic [3:0] rdata;
    logic       irq_ten_hz;
    logic       irq_one_hz;
  } bsw_state_t;

endpackage

// file: core/bsw_tick_div.sv
// Divider that makes the one-cycle 256 Hz tick enable from the system clock.
module bsw_tick_div #(
  parameter int DIV = 781250
) (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Tick enable.
  output logic      tick_out
);
  import bsw_pkg::*;

  localparam logic [19:0] LAST = 20'(DIV - 1);

  bsw_div_state_t st;
  bsw_div_state_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST)
    begin
      next_st.cnt  = 20'h00000;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 20'h00001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule // bsw_tick_div

// file: core/bsw_step_seq.sv
// Step sequencer that turns 256 Hz ticks into uneven hundredths advances.
`include "bsw_cfg.svh"
module bsw_step_seq (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Control.
  input  wire logic       tick_in,
  input  wire logic       run_in,
  input  wire logic       clear_in,
  // Current digits.
  input  wire logic [3:0] hund_in,
  input  wire logic [3:0] tenth_in,
  // Advance pulse.
  output logic            adv_out
);
  import bsw_pkg::*;

  // Ticks spent on one hundredths step, chosen by both digits.
  function automatic logic [1:0] step_len(input logic [3:0] d, input logic [3:0] t);
    logic long_dec;
    logic long_step;
    long_dec  = !(t == 4'h0 || t == 4'h3 || t == 4'h5 || t == 4'h8);
    long_step = d[0] || (long_dec && d == 4'h8);
    step_len  = long_step ? `BSW_STEP_LONG : `BSW_STEP_SHORT;
  endfunction

  bsw_seq_state_t st;
  bsw_seq_state_t next_st;
  logic [1:0]     len;

  always_comb
  begin
    len         = step_len(hund_in, tenth_in);
    next_st     = st;
    next_st.adv = 1'b0;
    if (clear_in)
    begin
      next_st.sub = 2'h0;
    end
    else if (run_in && tick_in)
    begin
      if (st.sub == len - 2'h1)
      begin
        next_st.sub = 2'h0;
        next_st.adv = 1'b1;
      end
      else
      begin
        next_st.sub = st.sub + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign adv_out = st.adv;

endmodule // bsw_step_seq

// file: test/bsw_assertions.sv
// Concurrent checks on the stopwatch register port and interrupt outputs.
module bsw_assertions #(
  parameter int TICK_DIV = 16
) (
  // Clock and reset.
  input wire logic        CLK_IN,
  input wire logic        RESET_IN,
  // Register port.
  input wire logic [15:0] ADDR_IN,
  input wire logic [3:0]  WR_DATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [3:0]  RD_DATA_OUT,
  // Requests and status.
  input wire logic        IRQ_TEN_HZ_OUT,
  input wire logic        IRQ_ONE_HZ_OUT,
  input wire logic        RUNNING_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] mask;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // Mirror of the mask register, rebuilt from the writes seen on the port.
  always_ff @(posedge CLK_IN or posedge RESET_IN)
    if (RESET_IN)
      mask <= 2'h0;
    else if (WR_IN && ADDR_IN == 16'hFFE7)
      mask <= WR_DATA_IN[1:0];
  chk_run_write: assert property (WR_IN && ADDR_IN == 16'hFF7C
    |=> RUNNING_OUT == $past(WR_DATA_IN[0])) else $error("run bit not taken");
  chk_run_hold: assert property ($changed(RUNNING_OUT)
    |-> $past(WR_IN && ADDR_IN == 16'hFF7C)) else $error("run bit moved alone");
  chk_ctrl_read: assert property (RD_IN && ADDR_IN == 16'hFF7C
    |=> RD_DATA_OUT == {3'h0, RUNNING_OUT}) else $error("control read wrong");
  chk_digit_bcd: assert property (RD_IN && ADDR_IN inside {16'hFF7D, 16'hFF7E}
    |=> RD_DATA_OUT <= 4'h9) else $error("digit not BCD");
  chk_mask_read: assert property (RD_IN && ADDR_IN == 16'hFFE7
    |=> RD_DATA_OUT == {2'h0, $past(mask)}) else $error("mask read wrong");
  chk_flag_unused: assert property (RD_IN && ADDR_IN == 16'hFFF7
    |=> RD_DATA_OUT[3:2] == 2'h0) else $error("flag unused bits set");
  chk_irq_ten: assert property (IRQ_TEN_HZ_OUT |-> $past(mask[0]))
    else $error("ten hertz request while masked");
  chk_irq_one: assert property (IRQ_ONE_HZ_OUT |-> $past(mask[1]))
    else $error("one hertz request while masked");
  chk_rd_idle: assert property (!RD_IN |=> RD_DATA_OUT == 4'h0)
    else $error("read data outside read cycle");
endmodule // bsw_assertions

bind bsw_top bsw_assertions #(.TICK_DIV(TICK_DIV)) i_bsw_assertions (.CLK_IN, .RESET_IN,
  .ADDR_IN, .WR_DATA_IN, .WR_IN, .RD_IN, .RD_DATA_OUT, .IRQ_TEN_HZ_OUT, .IRQ_ONE_HZ_OUT,
  .RUNNING_OUT);

// file: test/bsw_host.sv
// Bus master model standing in for the processor software.
module bsw_host (
  // Clock.
  input  wire logic             clk_in,
  // Register port.
  output bsw_pkg::bsw_bus_req_t bus_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import bsw_pkg::*;
  initial bus_out = '0;
  // Released address and data are scrambled so no stale value is trusted.
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk_in);
    bus_out <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus_out <= '{~a, ~d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_in);
    bus_out <= '{a, 4'h0, 1'b0, 1'b1};
    @(posedge clk_in);
    bus_out <= '{~a, 4'hF, 1'b0, 1'b0};
  endtask
endmodule // bsw_host

// file: test/bcd_stopwatch_timer_bench.sv
// Self-checking bench of the stopwatch.
module bcd_stopwatch_timer_bench import bsw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 16;
  localparam logic [15:0] CTL = 16'hFF7C, HUN = 16'hFF7D, TEN = 16'hFF7E;
  localparam logic [15:0] MSK = 16'hFFE7, FLG = 16'hFFF7;
  logic         clk;
  logic         rst = 1'b0;
  logic         pend = 1'b0;
  logic         irq10, irq1, running;
  logic [3:0]   rdata;
  logic [3:0]   q[$];
  logic [7:0]   e;
  logic [31:0]  v;
  logic [31:0]  seed = 32'h0D989445;
  logic [15:0]  regs[6] = '{CTL, HUN, TEN, MSK, FLG, 16'h0000};
  int           fail_count = 0, compares = 0, cyc = 0;
  bsw_bus_req_t bus;

  bsw_host i_bsw_host (.clk_in(clk), .bus_out(bus));
  bsw_top #(.TICK_DIV(DIV)) i_bsw_top (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(bus.addr),
    .WR_DATA_IN(bus.wdata), .WR_IN(bus.wr), .RD_IN(bus.rd), .RD_DATA_OUT(rdata),
    .IRQ_TEN_HZ_OUT(irq10), .IRQ_ONE_HZ_OUT(irq1), .RUNNING_OUT(running));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] dig(int n);
    int h = 0, t = 0, c = 0;
    for (int i = 0; i < n; i++)
    begin
      c++;
      if (c == ((h % 2 == 1 || (h == 8 && !(t inside {0, 3, 5, 8}))) ? 3 : 2))
      begin
        c = 0;
        h = (h + 1) % 10;
        if (h == 0)
          t = (t + 1) % 10;
      end
    end
    return {t[3:0], h[3:0]};
  endfunction

  task automatic cmp(logic [3:0] got, logic [3:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [3:0] d);
    i_bsw_host.wr(a, d);
  endtask

  task automatic chk_rd(logic [15:0] a, logic [3:0] x);
    q.push_back(x);
    i_bsw_host.rd(a);
  endtask

  // Window edges sit half a tick away from any tick, so tick counts are exact.
  task automatic algn();
    do @(posedge clk); while (cyc % DIV != DIV / 2);
  endtask

  task automatic seg(logic [3:0] ctl, int n);
    wr(CTL, ctl);
    repeat (n * DIV - 2) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= rst ? 0 : cyc + 1;
    if (pend)
      cmp(rdata, q.pop_front());
    pend <= bus.rd;
  end

  initial
  begin
    #200000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) chk_rd(regs[i], 4'h0);
    wr(HUN, 4'hF);
    chk_rd(HUN, 4'h0);
    for (int i = 0; i < 4; i++)
    begin
      v = xs();
      wr(MSK, v[3:0]);
      chk_rd(MSK, {2'h0, v[1:0]});
    end
    wr(MSK, 4'h3);
    algn();
    seg(4'h3, 27);
    wr(CTL, 4'h0);
    e = dig(27);
    chk_rd(HUN, e[3:0]);
    chk_rd(TEN, e[7:4]);
    chk_rd(FLG, 4'h1);
    chk_rd(CTL, 4'h0);
    cmp(irq10, 1'b1);
    cmp(irq1, 1'b0);
    wr(FLG, 4'h3);
    chk_rd(FLG, 4'h0);
    wr(MSK, 4'h0);
    algn();
    seg(4'h1, 232);
    wr(CTL, 4'h0);
    e = dig(259);
    chk_rd(HUN, e[3:0]);
    chk_rd(TEN, e[7:4]);
    chk_rd(FLG, 4'h3);
    cmp(irq10, 1'b0);
    cmp(irq1, 1'b0);
    wr(MSK, 4'h3);
    repeat (2) @(posedge clk);
    cmp(irq10, 1'b1);
    cmp(irq1, 1'b1);
    wr(FLG, 4'h1);
    chk_rd(FLG, 4'h2);
    wr(MSK, 4'h1);
    repeat (2) @(posedge clk);
    cmp(irq1, 1'b0);
    wr(MSK, 4'h2);
    repeat (2) @(posedge clk);
    cmp(irq1, 1'b1);
    cmp(irq10, 1'b0);
    wr(CTL, 4'h2);
    chk_rd(HUN, 4'h0);
    chk_rd(TEN, 4'h0);
    cmp({3'h0, running}, 4'h0);
    algn();
    seg(4'h1, 10);
    seg(4'h3, 7);
    wr(CTL, 4'h0);
    e = dig(7);
    chk_rd(HUN, e[3:0]);
    chk_rd(TEN, e[7:4]);
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule // bcd_stopwatch_timer_bench
